// ### rtl/trig_cfg_pkg.sv
/*
  Constants for the trigger and readout opcode interpreter.
  Assumes a single 250 MHz clock and a synchronous active-high reset.
*/
package trig_cfg_pkg;
  localparam logic [7:0] OP_SET_WIDTH = 8'h10;
  localparam logic [7:0] OP_SET_OFFSET = 8'h11;
  localparam logic [7:0] OP_SET_EXTRA = 8'h12;
  localparam logic [7:0] OP_SET_REJECT = 8'h13;
  localparam logic [7:0] OP_SUB_ON = 8'h14;
  localparam logic [7:0] OP_SUB_OFF = 8'h15;
  localparam logic [7:0] OP_RD_TRIG = 8'h16;
  localparam logic [7:0] OP_SET_EDGE = 8'h22;
  localparam logic [7:0] OP_RD_EDGE = 8'h23;
  localparam logic [7:0] OP_SET_RES = 8'h24;
  localparam logic [7:0] OP_SET_PAIR_RES = 8'h25;
  localparam logic [7:0] OP_RD_RES = 8'h26;
  localparam logic [7:0] OP_SET_DEAD = 8'h28;
  localparam logic [7:0] OP_RD_DEAD = 8'h29;
  localparam logic [7:0] OP_HDR_ON = 8'h30;
  localparam logic [7:0] OP_HDR_OFF = 8'h31;
  localparam logic [7:0] OP_RD_HDR = 8'h32;
  localparam logic [7:0] OP_SET_HITS = 8'h33;
  localparam logic [1:0] ADDR_CMD = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [11:0] RST_WIDTH = 12'h014;
  localparam logic [15:0] RST_OFFSET = 16'hFFD8;
  localparam logic [11:0] RST_EXTRA = 12'h008;
  localparam logic [11:0] RST_REJECT = 12'h004;
  localparam logic RST_SUB = 1'b0;
  localparam logic [1:0] RST_EDGE = 2'h2;
  localparam logic [1:0] RST_RES = 2'h3;
  localparam logic [2:0] RST_PAIR_LEAD = 3'h0;
  localparam logic [3:0] RST_PAIR_WIDTH = 4'h0;
  localparam logic [1:0] RST_DEAD = 2'h0;
  localparam logic RST_HDR = 1'b0;
  localparam logic [3:0] RST_HITS = 4'h9;
  localparam logic [15:0] SIZE_ERR_FLAG = 16'h1000;
  localparam logic [1:0] EDGE_PAIR = 2'h0;
  localparam logic [3:0] HITS_NOLIMIT = 4'h9;
  localparam logic [2:0] RD_WORDS_TRIG = 3'h5;
  typedef enum logic [1:0] {ST_IDLE, ST_WR, ST_RD} phase_type;
  typedef struct packed {
    phase_type phase;
    logic [7:0] op;
    logic [2:0] idx;
    logic [11:0] width;
    logic [15:0] offset;
    logic [11:0] extra;
    logic [11:0] reject;
    logic sub;
    logic [1:0] edge_mode;
    logic [1:0] res;
    logic [2:0] pair_lead;
    logic [3:0] pair_width;
    logic [1:0] dead;
    logic hdr;
    logic [3:0] hits;
    logic [15:0] rdata;
    logic [8:0] hit_cnt;
    logic over;
    logic [15:0] err_word;
    logic err_valid;
  } state_type;
endpackage

// ### rtl/trig_cfg_ctrl.sv
/*
  Opcode interpreter holding trigger-matching and readout settings.
  Assumes a host on a plain register port (address, strobes, data) and
  a hit stream from the acquisition logic on the same clock.
*/
`timescale 1ns/1ps
// What this block does
// - After a write opcode, wait for every parameter word; ignore new opcodes.
// - After a read opcode, hold until all answer words are read.
// - Window width is bits 11..0, default 0x14, counted in clock periods.
// - Offset is stored as a cycle count, default 0xFFD8.
// - Extra search margin keeps 12 bits, top four ignored, default 0x08.
// - Reject margin keeps 12 bits, default 0x04.
// - 14xx enables trigger-time subtraction, 15xx disables it.
// - 16xx returns width, offset, extra, reject, then subtraction flag.
// - 22xx sets edge detection from the low two bits.
// - 23xx returns edge detection in the low two bits.
// - 24xx sets edge resolution from bits 1..0, default 25 ps code.
// - 25xx sets pair lead code bits 2..0 and width code bits 11..8.
// - 26xx returns edge resolution or, in pair mode, both pair codes.
// - 28xx sets dead time code, default 00; 29xx reads it back.
// - 30xx enables header and trailer, 31xx disables them.
// - 32xx returns header and trailer enable in bit 0.
// - 33xx sets hit-limit code, default 1001 meaning no limit.
// - Exceeded hit limit emits error word 0x1000 before the trailer.
module trig_cfg_ctrl
  import trig_cfg_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [1:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [15:0] O_RDATA,
  input wire logic I_EVT_START,
  input wire logic I_HIT,
  input wire logic I_EVT_END,
  output logic [15:0] O_ERR_WORD,
  output logic O_ERR_VALID,
  output logic [11:0] O_WIDTH,
  output logic [15:0] O_OFFSET,
  output logic [11:0] O_EXTRA,
  output logic [11:0] O_REJECT,
  output logic O_SUB_EN,
  output logic [1:0] O_EDGE,
  output logic [1:0] O_RES,
  output logic [2:0] O_PAIR_LEAD,
  output logic [3:0] O_PAIR_WIDTH,
  output logic [1:0] O_DEAD,
  output logic O_HDR_EN,
  output logic [3:0] O_HITS,
  output logic O_BUSY
);
  import trig_cfg_pkg::*;

  state_type cur_ff;
  state_type nxt_cur;

  function automatic logic [2:0] rd_words(input logic [7:0] op);
    case (op)
      OP_RD_TRIG: rd_words = RD_WORDS_TRIG;
      OP_RD_EDGE, OP_RD_RES, OP_RD_DEAD, OP_RD_HDR: rd_words = 3'h1;
      default: rd_words = 3'h0;
    endcase
  endfunction

  function automatic logic is_wr_op(input logic [7:0] op);
    case (op)
      OP_SET_WIDTH, OP_SET_OFFSET, OP_SET_EXTRA, OP_SET_REJECT,
      OP_SET_EDGE, OP_SET_RES, OP_SET_PAIR_RES, OP_SET_DEAD,
      OP_SET_HITS: is_wr_op = 1'b1;
      default: is_wr_op = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] answer(input state_type s, input logic [2:0] i);
    answer = 16'h0000;
    case (s.op)
      OP_RD_TRIG:
      begin
        case (i)
          3'h0: answer = {4'h0, s.width};
          3'h1: answer = s.offset;
          3'h2: answer = {4'h0, s.extra};
          3'h3: answer = {4'h0, s.reject};
          default: answer = {15'h0000, s.sub};
        endcase
      end
      OP_RD_EDGE: answer = {14'h0000, s.edge_mode};
      OP_RD_RES:
      begin
        if (s.edge_mode == EDGE_PAIR)
          answer = {4'h0, s.pair_width, 5'h00, s.pair_lead};
        else
          answer = {14'h0000, s.res};
      end
      OP_RD_DEAD: answer = {14'h0000, s.dead};
      OP_RD_HDR: answer = {15'h0000, s.hdr};
      default: answer = 16'h0000;
    endcase
  endfunction

  function automatic logic [8:0] hit_limit(input logic [3:0] code);
    if (code == 4'h0)
      hit_limit = 9'h000;
    else
      hit_limit = 9'(9'h001 << (code - 4'h1));
  endfunction

  logic cmd_wr;
  logic cmd_rd;
  logic [7:0] opc;

  always_comb
  begin
    cmd_wr = I_WR && (I_ADDR == ADDR_CMD);
    cmd_rd = I_RD && (I_ADDR == ADDR_CMD);
    opc = I_WDATA[15:8];
    nxt_cur = cur_ff;
    nxt_cur.err_valid = 1'b0;
    nxt_cur.rdata = 16'h0000;
    if (I_RD && I_ADDR == ADDR_STATUS)
      nxt_cur.rdata = {14'h0000, cur_ff.phase == ST_RD, cur_ff.phase == ST_WR};
    case (cur_ff.phase)
      ST_IDLE:
      begin
        if (cmd_wr)
        begin
          nxt_cur.op = opc;
          nxt_cur.idx = 3'h0;
          if (is_wr_op(opc))
            nxt_cur.phase = ST_WR;
          else if (rd_words(opc) != 3'h0)
            nxt_cur.phase = ST_RD;
          else if (opc == OP_SUB_ON)
            nxt_cur.sub = 1'b1;
          else if (opc == OP_SUB_OFF)
            nxt_cur.sub = 1'b0;
          else if (opc == OP_HDR_ON)
            nxt_cur.hdr = 1'b1;
          else if (opc == OP_HDR_OFF)
            nxt_cur.hdr = 1'b0;
        end
      end
      ST_WR:
      begin
        if (cmd_wr)
        begin
          nxt_cur.phase = ST_IDLE;
          case (cur_ff.op)
            OP_SET_WIDTH: nxt_cur.width = I_WDATA[11:0];
            OP_SET_OFFSET: nxt_cur.offset = I_WDATA;
            OP_SET_EXTRA: nxt_cur.extra = I_WDATA[11:0];
            OP_SET_REJECT: nxt_cur.reject = I_WDATA[11:0];
            OP_SET_EDGE: nxt_cur.edge_mode = I_WDATA[1:0];
            OP_SET_RES: nxt_cur.res = I_WDATA[1:0];
            OP_SET_PAIR_RES:
            begin
              nxt_cur.pair_lead = I_WDATA[2:0];
              nxt_cur.pair_width = I_WDATA[11:8];
            end
            OP_SET_DEAD: nxt_cur.dead = I_WDATA[1:0];
            OP_SET_HITS: nxt_cur.hits = I_WDATA[3:0];
            default: nxt_cur.phase = ST_IDLE;
          endcase
        end
      end
      ST_RD:
      begin
        if (cmd_rd)
        begin
          nxt_cur.rdata = answer(cur_ff, cur_ff.idx);
          nxt_cur.idx = 3'(cur_ff.idx + 3'h1);
          if (3'(cur_ff.idx + 3'h1) == rd_words(cur_ff.op))
            nxt_cur.phase = ST_IDLE;
        end
      end
      default: nxt_cur.phase = ST_IDLE;
    endcase
    if (I_EVT_START)
    begin
      nxt_cur.hit_cnt = 9'h000;
      nxt_cur.over = 1'b0;
    end
    else if (I_HIT)
    begin
      if (cur_ff.hits != HITS_NOLIMIT && cur_ff.hit_cnt >= hit_limit(cur_ff.hits))
        nxt_cur.over = 1'b1;
      else
        nxt_cur.hit_cnt = 9'(cur_ff.hit_cnt + 9'h001);
    end
    if (I_EVT_END && (cur_ff.over || (I_HIT && !I_EVT_START && nxt_cur.over)))
    begin
      nxt_cur.err_word = SIZE_ERR_FLAG;
      nxt_cur.err_valid = 1'b1;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      cur_ff <= '0;
      cur_ff.phase <= ST_IDLE;
      cur_ff.width <= RST_WIDTH;
      cur_ff.offset <= RST_OFFSET;
      cur_ff.extra <= RST_EXTRA;
      cur_ff.reject <= RST_REJECT;
      cur_ff.sub <= RST_SUB;
      cur_ff.edge_mode <= RST_EDGE;
      cur_ff.res <= RST_RES;
      cur_ff.pair_lead <= RST_PAIR_LEAD;
      cur_ff.pair_width <= RST_PAIR_WIDTH;
      cur_ff.dead <= RST_DEAD;
      cur_ff.hdr <= RST_HDR;
      cur_ff.hits <= RST_HITS;
    end
    else
      cur_ff <= nxt_cur;
  end

  assign O_RDATA = cur_ff.rdata;
  assign O_ERR_WORD = cur_ff.err_word;
  assign O_ERR_VALID = cur_ff.err_valid;
  assign O_WIDTH = cur_ff.width;
  assign O_OFFSET = cur_ff.offset;
  assign O_EXTRA = cur_ff.extra;
  assign O_REJECT = cur_ff.reject;
  assign O_SUB_EN = cur_ff.sub;
  assign O_EDGE = cur_ff.edge_mode;
  assign O_RES = cur_ff.res;
  assign O_PAIR_LEAD = cur_ff.pair_lead;
  assign O_PAIR_WIDTH = cur_ff.pair_width;
  assign O_DEAD = cur_ff.dead;
  assign O_HDR_EN = cur_ff.hdr;
  assign O_HITS = cur_ff.hits;
  assign O_BUSY = cur_ff.phase != ST_IDLE;

  AST_WR_STALL: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_IDLE && I_WR && I_ADDR == ADDR_CMD && I_WDATA[15:8] == OP_SET_WIDTH)
    ##1 (I_WR && I_ADDR == ADDR_CMD) |=> O_WIDTH == $past(I_WDATA[11:0]) && !O_BUSY)
    else $error("width word not taken");
  AST_RD_HOLD: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_RD && !(I_RD && I_ADDR == ADDR_CMD)) |=> O_BUSY)
    else $error("read wait left early");
  AST_WIDTH_DEF: assert property (@(posedge I_CLK)
    $past(I_RST) |-> O_WIDTH == 12'h014)
    else $error("width default wrong");
  AST_OFFS_DEF: assert property (@(posedge I_CLK)
    $past(I_RST) |-> O_OFFSET == 16'hFFD8 && O_EXTRA == 12'h008 && O_REJECT == 12'h004)
    else $error("offset or margin default wrong");
  AST_SUB_ON: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_IDLE && I_WR && I_ADDR == ADDR_CMD && I_WDATA[15:8] == 8'h14)
    |=> O_SUB_EN)
    else $error("subtraction not enabled");
  AST_RD_EDGE: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_RD && cur_ff.op == OP_RD_EDGE && I_RD && I_ADDR == ADDR_CMD)
    |=> O_RDATA == {14'h0000, $past(O_EDGE)})
    else $error("edge readback wrong");
  AST_HDR_OFF: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_IDLE && I_WR && I_ADDR == ADDR_CMD && I_WDATA[15:8] == 8'h31)
    |=> !O_HDR_EN)
    else $error("header not disabled");
  AST_HITS_DEF: assert property (@(posedge I_CLK)
    $past(I_RST) |-> O_HITS == 4'h9)
    else $error("hit limit default wrong");
  AST_ERR_WORD: assert property (@(posedge I_CLK) disable iff (I_RST)
    O_ERR_VALID |-> $past(I_EVT_END) && O_ERR_WORD == 16'h1000)
    else $error("error word value wrong");
  AST_WR_WAIT: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_WR && !cmd_wr)
    |=> O_BUSY && $stable(cur_ff.op))
    else $error("parameter wait left early");
  AST_STAT_WR: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_WR && I_RD && I_ADDR == ADDR_STATUS)
    |=> O_RDATA == 16'h0001)
    else $error("status does not show parameter wait");
  AST_RD_COUNT: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_RD && cmd_rd && 3'(cur_ff.idx + 3'h1) != rd_words(cur_ff.op))
    |=> O_BUSY)
    else $error("read wait left before last word");
  AST_RD_LAST: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_RD && cmd_rd && 3'(cur_ff.idx + 3'h1) == rd_words(cur_ff.op))
    |=> !O_BUSY)
    else $error("read wait kept after last word");
  AST_RD_IGN_WR: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_RD && cmd_wr && !I_RD)
    |=> O_BUSY && $stable(O_WIDTH) && $stable(O_DEAD) && $stable(O_EDGE))
    else $error("write taken during read wait");
  AST_RD_IDLE: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_IDLE && cmd_rd)
    |=> O_RDATA == 16'h0000)
    else $error("idle command read not zero");
  AST_LOW_BYTE: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_IDLE && cmd_wr && I_WDATA[15:8] == OP_SET_EDGE)
    |=> O_BUSY && cur_ff.op == OP_SET_EDGE)
    else $error("opcode not decoded from high byte");
  AST_OFFS_SET: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_WR && cur_ff.op == OP_SET_OFFSET && cmd_wr)
    |=> O_OFFSET == $past(I_WDATA))
    else $error("offset word not stored");
  AST_EXTRA_SET: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_WR && cur_ff.op == OP_SET_EXTRA && cmd_wr)
    |=> O_EXTRA == $past(I_WDATA[11:0]))
    else $error("extra margin not stored");
  AST_REJ_SET: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_WR && cur_ff.op == OP_SET_REJECT && cmd_wr)
    |=> O_REJECT == $past(I_WDATA[11:0]))
    else $error("reject margin not stored");
  AST_EDGE_SET: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_WR && cur_ff.op == OP_SET_EDGE && cmd_wr)
    |=> O_EDGE == $past(I_WDATA[1:0]))
    else $error("edge mode not stored");
  AST_RES_SET: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_WR && cur_ff.op == OP_SET_RES && cmd_wr)
    |=> O_RES == $past(I_WDATA[1:0]))
    else $error("edge resolution not stored");
  AST_PAIR_SET: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_WR && cur_ff.op == OP_SET_PAIR_RES && cmd_wr)
    |=> O_PAIR_LEAD == $past(I_WDATA[2:0]) && O_PAIR_WIDTH == $past(I_WDATA[11:8]))
    else $error("pair resolution not stored");
  AST_DEAD_SET: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_WR && cur_ff.op == OP_SET_DEAD && cmd_wr)
    |=> O_DEAD == $past(I_WDATA[1:0]))
    else $error("dead time not stored");
  AST_HITS_SET: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_WR && cur_ff.op == OP_SET_HITS && cmd_wr)
    |=> O_HITS == $past(I_WDATA[3:0]))
    else $error("hit limit not stored");
  AST_HDR_ON: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_IDLE && cmd_wr && I_WDATA[15:8] == OP_HDR_ON)
    |=> O_HDR_EN)
    else $error("header not enabled");
  AST_TRIG_W0: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_RD && cur_ff.op == OP_RD_TRIG && cmd_rd && cur_ff.idx == 3'h0)
    |=> O_RDATA == {4'h0, $past(O_WIDTH)})
    else $error("first trigger word wrong");
  AST_TRIG_W4: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_RD && cur_ff.op == OP_RD_TRIG && cmd_rd && cur_ff.idx == 3'h4)
    |=> O_RDATA == {15'h0000, $past(O_SUB_EN)})
    else $error("fifth trigger word wrong");
  AST_RD_RES: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_RD && cur_ff.op == OP_RD_RES && cmd_rd && O_EDGE != EDGE_PAIR)
    |=> O_RDATA == {14'h0000, $past(O_RES)})
    else $error("edge resolution readback wrong");
  AST_RD_PAIR: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_RD && cur_ff.op == OP_RD_RES && cmd_rd && O_EDGE == EDGE_PAIR)
    |=> O_RDATA == {4'h0, $past(O_PAIR_WIDTH), 5'h00, $past(O_PAIR_LEAD)})
    else $error("pair resolution readback wrong");
  AST_RD_HDR: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cur_ff.phase == ST_RD && cur_ff.op == OP_RD_HDR && cmd_rd)
    |=> O_RDATA == {15'h0000, $past(O_HDR_EN)})
    else $error("header readback wrong");
  AST_ERR_SET: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_EVT_END && cur_ff.over)
    |=> O_ERR_VALID && O_ERR_WORD == SIZE_ERR_FLAG)
    else $error("error word missing after overflow");
  AST_ERR_NONE: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_EVT_END && !cur_ff.over && !I_HIT)
    |=> !O_ERR_VALID)
    else $error("error word without overflow");
  AST_OVER_ZERO: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_HIT && !I_EVT_START && O_HITS == 4'h0)
    |=> cur_ff.over)
    else $error("hit allowed with zero limit");
  AST_OVER_MAX: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_HIT && !I_EVT_START && O_HITS == 4'h8 && cur_ff.hit_cnt == 9'h080)
    |=> cur_ff.over)
    else $error("hit beyond largest limit allowed");
  AST_NOLIMIT: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_HIT && !I_EVT_START && !cur_ff.over && O_HITS == HITS_NOLIMIT)
    |=> !cur_ff.over)
    else $error("overflow with no limit");
  AST_RST_DEF2: assert property (@(posedge I_CLK)
    $past(I_RST) |-> O_RES == 2'h3 && O_DEAD == 2'h0 && O_EDGE == RST_EDGE
    && !O_SUB_EN && !O_HDR_EN && O_PAIR_LEAD == 3'h0 && O_PAIR_WIDTH == 4'h0)
    else $error("resolution or mode default wrong");
endmodule

// ### bench/cfg_host.sv
/*
  Host model issuing opcodes, parameter words and answer reads.
  Assumes the interpreter's register port on the same clock.
*/
`timescale 1ns/1ps
module cfg_host
  import trig_cfg_pkg::*;
(
  input wire logic i_clk,
  output logic [1:0] o_addr,
  output logic [15:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  input wire logic [15:0] i_rdata
);
  initial
  begin
    o_addr = ADDR_CMD;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  task automatic put(input logic [1:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
    #1;
  endtask
  task automatic get(input logic [1:0] a, output logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask
  task automatic set_cmd(input logic [7:0] op, input logic [7:0] lo, input logic [15:0] p);
    @(posedge i_clk);
    o_addr <= ADDR_CMD;
    o_wdata <= {op, lo};
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wdata <= p;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~p;
    #1;
  endtask
  task automatic qry(input logic [7:0] op, input logic [7:0] lo, input int n,
                     output logic [15:0] w [0:4]);
    put(ADDR_CMD, {op, lo});
    @(posedge i_clk);
    o_addr <= ADDR_CMD;
    o_rd <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      @(posedge i_clk);
      if (i == n - 1)
        o_rd <= 1'b0;
      #1;
      w[i] = i_rdata;
    end
  endtask
endmodule

// ### bench/tdc_trigger_readout_opcodes_tb_top.sv
/*
  Self-checking bench for the opcode interpreter with a behavioural model.
  Assumes the host model and the interpreter on one 250 MHz clock.
*/
`timescale 1ns/1ps
module tdc_trigger_readout_opcodes_tb_top;
  import trig_cfg_pkg::*;
  logic clk, rst, evs, hit, eve, wr, rd, err_valid, sub_en, hdr_en, busy;
  logic [1:0] addr, edge_m, res, dead;
  logic [15:0] wdata, rdata, err_word, offset, e;
  logic [11:0] width, extra, reject;
  logic [2:0] pl;
  logic [3:0] pw, hits;
  logic [7:0] lo;
  logic [15:0] w [0:4];
  integer fails = 0, checks = 0, seed = 32'hE34D6205, i, j, lim;
  integer m_width = 'h14, m_offset = 'hFFD8, m_extra = 8, m_reject = 4, m_sub = 0;
  integer m_edge = RST_EDGE, m_res = 3, m_pl = 0, m_pw = 0, m_dead = 0, m_hdr = 0;
  cfg_host host(.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
    .i_rdata(rdata));
  trig_cfg_ctrl dut(.I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_EVT_START(evs), .I_HIT(hit), .I_EVT_END(eve),
    .O_ERR_WORD(err_word), .O_ERR_VALID(err_valid), .O_WIDTH(width), .O_OFFSET(offset),
    .O_EXTRA(extra), .O_REJECT(reject), .O_SUB_EN(sub_en), .O_EDGE(edge_m), .O_RES(res),
    .O_PAIR_LEAD(pl), .O_PAIR_WIDTH(pw), .O_DEAD(dead), .O_HDR_EN(hdr_en), .O_HITS(hits),
    .O_BUSY(busy));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic trig_rd;
    host.qry(OP_RD_TRIG, lo, 5, w);
    chk(w[0], m_width);
    chk(w[1], m_offset);
    chk(w[2], m_extra);
    chk(w[3], m_reject);
    chk(w[4], m_sub);
    chk(width, m_width);
    chk(offset, m_offset);
    chk(extra, m_extra);
    chk(reject, m_reject);
    chk(sub_en, m_sub);
  endtask
  task automatic others_rd;
    e = (m_edge == 0) ? {4'h0, m_pw[3:0], 5'h0, m_pl[2:0]} : m_res;
    host.qry(OP_RD_EDGE, lo, 1, w);
    chk(w[0], m_edge);
    host.qry(OP_RD_RES, lo, 1, w);
    chk(w[0], e);
    host.qry(OP_RD_DEAD, lo, 1, w);
    chk(w[0], m_dead);
    host.qry(OP_RD_HDR, lo, 1, w);
    chk(w[0], m_hdr);
    chk(edge_m, m_edge);
    chk(res, m_res);
    chk({pw, pl}, {m_pw[3:0], m_pl[2:0]});
    chk(hdr_en, m_hdr);
    chk(dead, m_dead);
  endtask
  task automatic evt(input integer n);
    @(posedge clk);
    evs <= 1'b1;
    @(posedge clk);
    evs <= 1'b0;
    repeat (n)
    begin
      @(posedge clk);
      hit <= 1'b1;
    end
    @(posedge clk);
    hit <= 1'b0;
    eve <= 1'b1;
    @(posedge clk);
    eve <= 1'b0;
    #1;
  endtask
  initial
  begin
    #200000;
    fails++;
    stop_test;
  end
  initial
  begin
    rst = 1'b1;
    evs = 1'b0;
    hit = 1'b0;
    eve = 1'b0;
    lo = 8'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    trig_rd();
    others_rd();
    host.get(ADDR_CMD, w[0]);
    chk(w[0], 0);
    host.put(ADDR_CMD, {OP_SET_WIDTH, 8'h00});
    chk(busy, 1);
    host.get(ADDR_STATUS, w[0]);
    chk(w[0], 1);
    host.put(ADDR_CMD, 16'h2300);
    m_width = 'h300;
    chk(busy, 0);
    chk(width, m_width);
    host.put(ADDR_CMD, {OP_RD_DEAD, 8'h5A});
    host.put(ADDR_CMD, 16'h2801);
    chk(busy, 1);
    host.get(ADDR_STATUS, w[0]);
    chk(w[0], 2);
    host.get(ADDR_CMD, w[0]);
    chk(w[0], m_dead);
    chk(busy, 0);
    host.put(2'h2, 16'h1000);
    host.get(2'h3, w[0]);
    chk(w[0], 0);
    chk(busy, 0);
    for (i = 0; i < 4; i++)
    begin
      lo = 8'($random(seed));
      m_width = (i == 0) ? 'hFFF : 1 + {$random(seed)} % 2088;
      m_offset = (-2048 + {$random(seed)} % 2089) & 'hFFFF;
      j = $random(seed);
      m_extra = j & 'hFFF;
      host.set_cmd(OP_SET_WIDTH, lo, m_width[15:0]);
      host.set_cmd(OP_SET_OFFSET, lo, m_offset[15:0]);
      host.set_cmd(OP_SET_EXTRA, lo, j[15:0]);
      j = $random(seed);
      m_reject = j & 'hFFF;
      host.set_cmd(OP_SET_REJECT, lo, j[15:0]);
      m_sub = i % 2;
      host.put(ADDR_CMD, {(m_sub == 1) ? OP_SUB_ON : OP_SUB_OFF, lo});
      trig_rd();
    end
    for (i = 0; i < 4; i++)
    begin
      lo = 8'($random(seed));
      m_edge = i;
      m_res = 3 - i;
      m_dead = i;
      m_hdr = (i + 1) % 2;
      host.set_cmd(OP_SET_EDGE, lo, {14'($random(seed)), i[1:0]});
      host.set_cmd(OP_SET_RES, lo, {14'h0, m_res[1:0]});
      host.set_cmd(OP_SET_DEAD, lo, {14'h0, m_dead[1:0]});
      if (i == 0)
      begin
        m_pl = {$random(seed)} % 8;
        m_pw = {$random(seed)} % 14;
        host.set_cmd(OP_SET_PAIR_RES, lo, {4'h0, m_pw[3:0], 5'h0, m_pl[2:0]});
      end
      host.put(ADDR_CMD, {(m_hdr == 1) ? OP_HDR_ON : OP_HDR_OFF, lo});
      others_rd();
    end
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    m_width = 'h14;
    m_offset = 'hFFD8;
    m_extra = 8;
    m_reject = 4;
    m_sub = 0;
    m_edge = RST_EDGE;
    m_res = 3;
    m_pl = 0;
    m_pw = 0;
    m_dead = 0;
    m_hdr = 0;
    trig_rd();
    others_rd();
    chk(hits, 4'h9);
    for (i = 0; i < 10; i++)
    begin
      host.set_cmd(OP_SET_HITS, lo, {12'h0, i[3:0]});
      chk(hits, i);
      lim = (i == 0) ? 0 : (i == 9) ? 200 : 1 << (i - 1);
      for (j = 0; j < 2; j++)
      begin
        evt(lim + j);
        chk(err_valid, (i != 9 && j == 1));
      end
    end
    chk(err_word, 16'h1000);
    stop_test;
  end
endmodule
